// ===== htf_checker.sv
// htf_checker.sv: port-level assertions for the transmit formatter.
// assumes a bind onto htf_formatter; one clock pclk, async reset presetn.
`timescale 1ns/1ps
module htf_checker (
  // apb side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // buffer side
  input wire buf_valid,
  input wire [7:0] buf_data,
  input wire buf_frame_end,
  input wire [7:0] buf_fill_count,
  input wire buf_check_suppress,
  input wire desc_hold,
  input wire buf_pop,
  // serial side and events
  input wire tx_bit_en,
  input wire tx_bit,
  input wire evt_frame_end,
  input wire evt_tx_abort,
  input wire evt_fill_change
);
  // ==========================================================
  // common clocking
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // first cycle of an access phase
  sequence s_enter;
    psel && penable && !$past(penable);
  endsequence
  // byte slot: no further take for seven cycles, strobes can be every cycle
  sequence s_quiet7;
    (!buf_pop)[*7];
  endsequence
  // a write transfer completed one or two edges ago
  sequence s_wrote;
    $past(psel && penable && pready && pwrite, 1) || $past(psel && penable && pready && pwrite, 2);
  endsequence
  // ==========================================================
  // apb answer
  a_apb_one_wait: assert property (s_enter |=> pready) else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  // ==========================================================
  // buffer takes
  a_pop_spacing: assert property (buf_pop |-> ##1 s_quiet7) else $error("pops too close");
  a_pop_cause: assert property (buf_pop |-> $past(buf_valid && tx_bit_en)) else $error("pop without byte");
  // ==========================================================
  // serial line moves only on strobes, never by buffer state
  a_bit_hold: assert property (!tx_bit_en |=> $stable(tx_bit)) else $error("tx bit moved");
  // ==========================================================
  // event pulses
  a_end_pulse: assert property (evt_frame_end |=> !evt_frame_end) else $error("frame end long");
  a_abort_pulse: assert property (evt_tx_abort |=> !evt_tx_abort) else $error("abort long");
  a_fill_cause: assert property (evt_fill_change |-> s_wrote) else $error("fill change no write");
endmodule // htf_checker

// ===== htf_formatter.v
// htf_formatter.v: per-channel transmit formatter with apb registers.
// assumes a byte source with valid/pop handshake and a one-cycle
// bit strobe from the time-slot logic; all inputs synchronous to pclk.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "htf_map.vh"

module htf_formatter (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // transmit buffer side
  input wire buf_valid,
  input wire [7:0] buf_data,
  input wire buf_frame_end,
  input wire [7:0] buf_fill_count,
  input wire buf_check_suppress,
  input wire desc_hold,
  output reg buf_pop,
  // serial slot side
  input wire tx_bit_en,
  output reg tx_bit,
  // event pulses
  output reg evt_frame_end,
  output reg evt_tx_abort,
  output reg evt_fill_change
);

  // ========================================================
  // state
  reg [15:0] ctrl; // software control word
  reg [2:0] state; // formatter state
  reg [7:0] sh; // byte being shifted out, lsb first
  reg [2:0] bcnt; // bit position within byte
  reg [2:0] ones; // run of ones in frame
  reg cur_last; // current byte closes the frame
  reg [7:0] cur_desc_fill_count; // fill count of current descriptor
  reg cur_csm; // per-descriptor check suppress
  reg [7:0] zcnt; // zeros inserted this frame
  reg [7:0] gap; // fill characters still owed
  reg [31:0] crc; // running check sequence
  reg [5:0] fbits; // check bits still to send
  reg fsel_q; // last fill select, for change event

  // ========================================================
  // next-value signals decided at each byte boundary
  reg [2:0] next_state;
  reg [1:0] next_ld;
  reg [7:0] next_gap;
  reg next_fe;
  reg next_ab;
  reg next_start;

  // ========================================================
  // control decode
  wire slot_transparent_mode = ctrl[`HTF_C_TMA];
  wire fa = ctrl[`HTF_C_FA];
  wire fsel = ctrl[`HTF_C_FSEL];
  wire crc32 = ctrl[`HTF_C_CRC32];
  wire hold = ctrl[`HTF_C_HOLD];
  wire nabort = ctrl[`HTF_C_NABORT];
  wire [7:0] tflag = ctrl[`HTF_C_TFLAG_HI:`HTF_C_TFLAG_LO];

  // fill character depends on mode
  wire [7:0] slot_fill_char = fa ? tflag : `HTF_ONES;
  wire [7:0] gap_fill_char = fsel ? `HTF_ONES : `HTF_FLAG;
  wire [7:0] fill_char = slot_transparent_mode ? slot_fill_char : gap_fill_char;

  // check sequence needs both suppress bits clear
  wire crc_on = ~ctrl[`HTF_C_CSUP] & ~cur_csm;

  // width select picks 16 or 32 bit sequence
  wire [5:0] fcs_len = crc32 ? `HTF_FCS32_BITS : `HTF_FCS16_BITS;
  wire [31:0] crc_init = crc32 ? `HTF_INIT32 : `HTF_INIT16;

  // gap adjustment by an eighth of the zero insertions
  wire [7:0] zdiv = {3'h0, zcnt[7:3]};
  wire [7:0] adj_desc_fill_count = (cur_desc_fill_count > zdiv) ? (cur_desc_fill_count - zdiv) : 8'h00;
  wire [7:0] eff = fa ? adj_desc_fill_count : cur_desc_fill_count;

  // a new frame only starts when nothing is holding it back
  wire blocked = hold | nabort | desc_hold;
  wire can_start = buf_valid & ~blocked;

  // stuffing happens only inside hdlc frame content
  // the first bit slot of the closing flag still counts as frame content, so a
  // run of five ones at the very end of the frame gets its zero before the flag
  wire close_edge = (state == `HTF_S_CLOSE) & (bcnt == 3'h0);
  wire in_frame = (state == `HTF_S_DATA) | (state == `HTF_S_FCS) | close_edge;
  wire stuffing = ~slot_transparent_mode & in_frame & (ones == `HTF_STUFF_RUN);
  wire boundary = (bcnt == 3'h7) & ~stuffing & (state != `HTF_S_FCS);

  // ========================================================
  // one step of the reflected crc shift register
  function [31:0] crc_step;
    input [31:0] c;
    input b;
    input w32;
    reg [31:0] poly;
    begin
      poly = w32 ? `HTF_POLY32 : `HTF_POLY16;
      crc_step = (c[0] ^ b) ? ((c >> 1) ^ poly) : (c >> 1);
    end
  endfunction

  // ========================================================
  // byte-boundary decision
  // only consulted when the last bit of a byte leaves; this keeps
  // every hold and abort aligned to whole characters on the line
  always @* begin
    next_state = state;
    next_ld = `HTF_LD_FILL;
    next_gap = gap;
    next_fe = 1'b0;
    next_ab = 1'b0;
    next_start = 1'b0;
    case (state)
      `HTF_S_IDLE: begin
        // hold or abort keeps the line in fill
        if (can_start) begin
          if (slot_transparent_mode) begin
            next_state = `HTF_S_DATA;
            next_ld = `HTF_LD_DATA;
          end else begin
            next_state = `HTF_S_OPEN;
            next_ld = `HTF_LD_FLAG;
          end
        end
      end
      `HTF_S_OPEN: begin
        // opening flag done; content follows if it is there
        if (buf_valid & ~nabort) begin
          next_state = `HTF_S_DATA;
          next_ld = `HTF_LD_DATA;
          next_start = 1'b1;
        end else begin
          next_state = `HTF_S_IDLE;
        end
      end
      `HTF_S_DATA: begin
        if (nabort) begin
          // normal abort cuts the frame, no further pops
          next_state = slot_transparent_mode ? `HTF_S_IDLE : `HTF_S_ABORT;
          next_ld = slot_transparent_mode ? `HTF_LD_FILL : `HTF_LD_ABORT;
          next_ab = 1'b1;
        end else if (cur_last) begin
          next_fe = 1'b1;
          if (slot_transparent_mode) begin
            // slot mode: stream stops and fill goes out
            next_state = `HTF_S_IDLE;
          end else if (crc_on) begin
            next_state = `HTF_S_FCS;
          end else begin
            next_state = `HTF_S_CLOSE;
            next_ld = `HTF_LD_FLAG;
          end
        end else if (desc_hold & ~slot_transparent_mode) begin
          // descriptor hold without frame end kills the frame
          next_state = `HTF_S_ABORT;
          next_ld = `HTF_LD_ABORT;
          next_ab = 1'b1;
        end else if (slot_transparent_mode & (hold | desc_hold)) begin
          // hold bites the outgoing stream at this byte boundary, without waiting for frame end
          next_state = `HTF_S_IDLE;
        end else if (buf_valid) begin
          next_ld = `HTF_LD_DATA;
        end else begin
          // underrun aborts the frame
          next_state = slot_transparent_mode ? `HTF_S_IDLE : `HTF_S_ABORT;
          next_ld = slot_transparent_mode ? `HTF_LD_FILL : `HTF_LD_ABORT;
          next_ab = 1'b1;
        end
      end
      `HTF_S_CLOSE: begin
        // closing flag done; gap follows the effective count
        if (blocked) begin
          // hold ignores the count entirely
          next_state = `HTF_S_IDLE;
        end else if (eff == 8'h00) begin
          // shared flag: next frame content follows at once
          if (buf_valid) begin
            next_state = `HTF_S_DATA;
            next_ld = `HTF_LD_DATA;
            next_start = 1'b1;
          end else begin
            next_state = `HTF_S_IDLE;
          end
        end else if (eff == 8'h01) begin
          next_state = `HTF_S_OPEN;
          next_ld = `HTF_LD_FLAG;
        end else begin
          // count-1 fills, first one loaded now
          next_state = `HTF_S_GAP;
          next_gap = eff - 8'h02;
        end
      end
      `HTF_S_GAP: begin
        if (blocked) begin
          // hold during fill: no more data until released
          next_state = `HTF_S_IDLE;
        end else if (gap == 8'h00) begin
          next_state = `HTF_S_OPEN;
          next_ld = `HTF_LD_FLAG;
        end else begin
          next_gap = gap - 8'h01;
        end
      end
      `HTF_S_ABORT: begin
        // abort character gone, fill follows
        next_state = `HTF_S_IDLE;
      end
      default: begin
        next_state = `HTF_S_IDLE;
      end
    endcase
  end

  // ========================================================
  // serial formatter
  // every step is paced by the slot strobe; the buffer pop is a
  // one-cycle pulse after the edge that takes the byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= `HTF_S_IDLE;
      sh <= `HTF_ONES;
      bcnt <= 3'h0;
      ones <= 3'h0;
      cur_last <= 1'b0;
      cur_desc_fill_count <= 8'h00;
      cur_csm <= 1'b0;
      zcnt <= 8'h00;
      gap <= 8'h00;
      crc <= `HTF_INIT32;
      fbits <= 6'h00;
      tx_bit <= 1'b1;
      buf_pop <= 1'b0;
      evt_frame_end <= 1'b0;
      evt_tx_abort <= 1'b0;
    end else begin
      buf_pop <= 1'b0;
      evt_frame_end <= 1'b0;
      evt_tx_abort <= 1'b0;
      if (tx_bit_en) begin
        if (stuffing) begin
          // forced zero, byte position does not advance
          tx_bit <= 1'b0;
          ones <= 3'h0;
          if (zcnt != 8'hFF) begin
            zcnt <= zcnt + 8'h01;
          end
        end else if (state == `HTF_S_FCS) begin
          // check sequence leaves inverted, lsb first
          tx_bit <= ~crc[0];
          crc <= crc >> 1;
          ones <= crc[0] ? 3'h0 : ones + 3'h1;
          fbits <= fbits - 6'h01;
          if (fbits == 6'h01) begin
            state <= `HTF_S_CLOSE;
            sh <= `HTF_FLAG;
            bcnt <= 3'h0;
          end
        end else begin
          // plain bit from the shifter
          tx_bit <= sh[0];
          sh <= sh >> 1;
          bcnt <= bcnt + 3'h1;
          if (state == `HTF_S_DATA) begin
            ones <= sh[0] ? ones + 3'h1 : 3'h0;
            crc <= crc_step(crc, sh[0], crc32);
          end else begin
            ones <= 3'h0;
          end
          if (boundary) begin
            state <= next_state;
            gap <= next_gap;
            fbits <= fcs_len;
            evt_frame_end <= next_fe;
            evt_tx_abort <= next_ab;
            if (next_start) begin
              crc <= crc_init;
              zcnt <= 8'h00;
            end
            case (next_ld)
              `HTF_LD_DATA: begin
                sh <= buf_data;
                buf_pop <= 1'b1;
                cur_last <= buf_frame_end;
                cur_desc_fill_count <= buf_fill_count;
                cur_csm <= buf_check_suppress;
              end
              `HTF_LD_FLAG: sh <= `HTF_FLAG;
              `HTF_LD_ABORT: sh <= `HTF_ABORT_CHAR;
              default: sh <= fill_char;
            endcase
          end
        end
      end
    end
  end

  // ========================================================
  // fill change event
  // a software change of the fill select shows up as a pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_q <= 1'b0;
      evt_fill_change <= 1'b0;
    end else begin
      fsel_q <= fsel;
      evt_fill_change <= fsel ^ fsel_q;
    end
  end

  // ========================================================
  // apb slave
  // one wait state: pready rises the cycle after the access phase
  // begins, so read data and error come from flops
  wire acc = psel & penable;
  wire hit_ctrl = (paddr == `HTF_CTRL_ADDR);
  wire hit_stat = (paddr == `HTF_STAT_ADDR);
  wire idle_hold = (state == `HTF_S_IDLE) & blocked;
  wire [31:0] stat_word = {16'h0000, zcnt, 4'h0, idle_hold, state};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `HTF_CTRL_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit_ctrl & ~hit_stat;
      if (acc & ~pready) begin
        // unmapped reads return zero
        if (pwrite) begin
          prdata <= 32'h00000000;
        end else if (hit_ctrl) begin
          prdata <= {16'h0000, ctrl};
        end else if (hit_stat) begin
          prdata <= stat_word;
        end else begin
          prdata <= 32'h00000000;
        end
      end
      // write lands at the completing edge; hold acts on the line
      if (acc & pready & pwrite & hit_ctrl) begin
        ctrl <= pwdata[15:0];
      end
    end
  end

endmodule // htf_formatter

// ===== htf_map.vh
// htf_map.vh: constants for the hdlc channel transmit formatter.
// assumes inclusion by htf_formatter.v; holds `define lines only.
//
// How it works
// - slot-mode hold sends ones or programmed flag
// - hold ignores fill count; release ends gap
// - hold acts on serial stream, not buffer
// - slot-mode frame end: stop data, send fill
// - hold during fill stops further data
// - normal abort: abort frame, fill, no pops
// - hdlc frame gets 7E opening, closing flags
// - insert zero after five ones in frame
// - optional check sequence; automatic gap fill
// - gap fill 7E when select 0, FF when 1
// - count 0 shared flag, 1 two, 2 flag-fill-flag
// - flag adjust off: count used unchanged
// - flag adjust on: count minus zeros/8, floor 0
// - events: frame end, abort, fill change
// - hdlc descriptor hold mid-frame aborts, then fills
// - channel hold: hdlc finishes frame, slot mode stops at byte; idle in fill
// - width select 0 gives 16, 1 gives 32 bits
// - check sequence only when both suppress bits clear
`ifndef HTF_MAP_VH
`define HTF_MAP_VH

// ==========================================================
// register map
`define HTF_CTRL_ADDR 12'h000
`define HTF_STAT_ADDR 12'h004

// ==========================================================
// control register fields
`define HTF_C_TMA 0
`define HTF_C_FA 1
`define HTF_C_FSEL 2
`define HTF_C_CRC32 3
`define HTF_C_CSUP 4
`define HTF_C_HOLD 5
`define HTF_C_NABORT 6
`define HTF_C_TFLAG_HI 15
`define HTF_C_TFLAG_LO 8
`define HTF_CTRL_RESET 16'h0000

// ==========================================================
// characters and check sequence
`define HTF_FLAG 8'h7E
`define HTF_ONES 8'hFF
`define HTF_ABORT_CHAR 8'hFF
`define HTF_STUFF_RUN 3'h5
`define HTF_POLY16 32'h00008408
`define HTF_POLY32 32'hEDB88320
`define HTF_INIT16 32'h0000FFFF
`define HTF_INIT32 32'hFFFFFFFF
`define HTF_FCS16_BITS 6'h10
`define HTF_FCS32_BITS 6'h20

// ==========================================================
// formatter states
`define HTF_S_IDLE 3'h0
`define HTF_S_OPEN 3'h1
`define HTF_S_DATA 3'h2
`define HTF_S_FCS 3'h3
`define HTF_S_CLOSE 3'h4
`define HTF_S_GAP 3'h5
`define HTF_S_ABORT 3'h6

// ==========================================================
// byte load selectors
`define HTF_LD_FILL 2'h0
`define HTF_LD_FLAG 2'h1
`define HTF_LD_DATA 2'h2
`define HTF_LD_ABORT 2'h3

`endif

// ===== htf_peer.sv
// htf_peer.sv: remote station model; makes bit strobes and watches the line.
// assumes tx_bit is lsb first and changes on the strobe edge.
`timescale 1ns/1ps
module htf_peer (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // line
  input wire tx_bit,
  input wire slow,
  output reg tx_bit_en,
  // observations
  output reg [7:0] win,
  output reg [15:0] flag_cnt
);
  reg [1:0] div; // divider for the slow strobe rate
  wire [7:0] next_win = {tx_bit, win[7:1]}; // lsb first fills from the top
  // ==========================================================
  // strobe maker and receiver; slow mode strobes every third cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_en <= 1'b0;
      div <= 2'h0;
      win <= 8'hFF;
      flag_cnt <= 16'h0000;
    end else begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      tx_bit_en <= !slow || (div == 2'h0);
      if (tx_bit_en) begin
        win <= next_win;
        // six ones between zeros only ever forms a flag
        if (next_win == 8'h7E) begin
          flag_cnt <= flag_cnt + 16'h0001;
        end
      end
    end
  end
endmodule // htf_peer

// ===== htf_tb.sv
// htf_tb.sv: self-checking bench for the transmit formatter.
// assumes htf_formatter, htf_peer and htf_checker are compiled before.
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // apb and buffer drives
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg buf_valid = 1'b0;
  reg [7:0] buf_data = 8'h00;
  reg buf_frame_end = 1'b0;
  reg [7:0] buf_fill_count = 8'h02;
  reg buf_check_suppress = 1'b0;
  reg desc_hold = 1'b0;
  reg slow = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, buf_pop, tx_bit_en, tx_bit;
  wire evt_frame_end, evt_tx_abort, evt_fill_change;
  wire [7:0] win;
  wire [15:0] flag_cnt;
  logic [7:0] q[$]; // bytes still to hand over, last one ends the frame
  int bad_count = 0, cmp_count = 0, pop_n = 0, fe_n = 0, ab_n = 0, fc_n = 0, p0, a0, f0, k;
  logic [31:0] rd;
  logic er;
  htf_formatter htf_formatter_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .buf_valid(buf_valid), .buf_data(buf_data), .buf_frame_end(buf_frame_end),
    .buf_fill_count(buf_fill_count), .buf_check_suppress(buf_check_suppress), .desc_hold(desc_hold),
    .buf_pop(buf_pop), .tx_bit_en(tx_bit_en), .tx_bit(tx_bit), .evt_frame_end(evt_frame_end),
    .evt_tx_abort(evt_tx_abort), .evt_fill_change(evt_fill_change));
  htf_peer htf_peer_inst (.pclk(pclk), .presetn(presetn), .tx_bit(tx_bit), .slow(slow),
    .tx_bit_en(tx_bit_en), .win(win), .flag_cnt(flag_cnt));
  initial forever #12.5 pclk = ~pclk;
  // ==========================================================
  // byte source advances on each take; events are counted here
  always @(posedge pclk) begin
    if (buf_pop === 1'b1 && q.size() > 0) begin
      void'(q.pop_front());
      pop_n++;
    end
    fe_n += (evt_frame_end === 1'b1);
    ab_n += (evt_tx_abort === 1'b1);
    fc_n += (evt_fill_change === 1'b1);
    buf_valid <= (q.size() > 0);
    buf_data <= (q.size() > 0) ? q[0] : 8'h00;
    buf_frame_end <= (q.size() == 1);
  end
  // ==========================================================
  // helpers
  task chk(input [31:0] seen, input [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits for pready, bounded
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // repeated character seen at any bit phase
  function automatic bit rot(input [7:0] w, input [7:0] c);
    logic [15:0] d;
    d = {w, w};
    rot = 0;
    for (int i = 0; i < 8; i++) if (d[i+:8] == c) rot = 1;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task drain;
    for (k = 0; k < 3000 && q.size() > 0; k++) @(posedge pclk);
    chk(q.size(), 0);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog: the tests need well under two thousand cycles
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    chk(tx_bit, 1);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0);
    apb(0, 12'h008, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    cyc(40);
    chk(rot(win, 8'h7E), 1);
    apb(1, 12'h000, 32'h14);
    cyc(3);
    chk(fc_n, 1);
    apb(0, 12'h000, 0);
    chk(rd, 32'h14);
    cyc(40);
    chk(win, 8'hFF);
    // sixteen ones: zeros go in after the 5th, 10th and 15th
    f0 = flag_cnt;
    q.push_back(8'hFF);
    q.push_back(8'hFF);
    for (k = 0; k < 2000 && fe_n == 0; k++) @(posedge pclk);
    chk(fe_n, 1);
    cyc(40);
    chk(flag_cnt - f0 >= 2, 1);
    apb(0, 12'h004, 0);
    chk(rd[15:8], 8'h03);
    // normal abort in mid-frame
    for (int i = 0; i < 6; i++) q.push_back(8'h55);
    p0 = pop_n;
    for (k = 0; k < 2000 && pop_n == p0; k++) @(posedge pclk);
    a0 = ab_n;
    apb(1, 12'h000, 32'h54);
    p0 = pop_n;
    cyc(120);
    chk(pop_n - p0 <= 1, 1);
    chk(ab_n - a0, 1);
    chk(win, 8'hFF);
    apb(0, 12'h004, 0);
    chk(rd[3], 1);
    apb(1, 12'h000, 32'h14);
    drain;
    // one-byte frame with a 32-bit check sequence must close and go idle
    apb(1, 12'h000, 32'h08);
    f0 = fe_n;
    q.push_back(8'h00);
    for (k = 0; k < 2000 && fe_n == f0; k++) @(posedge pclk);
    chk(fe_n - f0, 1);
    cyc(120);
    apb(0, 12'h004, 0);
    chk(rd[2:0], 3'h0);
    // slot mode, channel hold with flag adjust, slow strobes
    slow <= 1'b1;
    // hold is raised while the buffer is empty, so no poll is outstanding
    apb(1, 12'h000, 32'hA523);
    cyc(150);
    chk(rot(win, 8'hA5), 1);
    for (int i = 0; i < 3; i++) q.push_back(8'h3C);
    p0 = pop_n;
    cyc(150);
    chk(pop_n - p0, 0);
    apb(1, 12'h000, 32'h21);
    cyc(150);
    chk(win, 8'hFF);
    apb(1, 12'h000, 32'h01);
    drain;
    cyc(150);
    chk(win, 8'hFF);
    test_done;
  end
endmodule // tb
bind htf_formatter htf_checker htf_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .buf_valid(buf_valid), .buf_data(buf_data), .buf_frame_end(buf_frame_end),
  .buf_fill_count(buf_fill_count), .buf_check_suppress(buf_check_suppress), .desc_hold(desc_hold),
  .buf_pop(buf_pop), .tx_bit_en(tx_bit_en), .tx_bit(tx_bit), .evt_frame_end(evt_frame_end),
  .evt_tx_abort(evt_tx_abort), .evt_fill_change(evt_fill_change));
